/* File: rtl/dio_cfg.svh */
// Summary of operation
// - Inputs are sampled once per millisecond tick; shorter level changes are seen only if they span a sample point.
// - Enable mask bits 0,1,2 are negative limit, positive limit, home for inputs 1-3.
// - Enable bit one turns a special function on; level bits 16-31 ignore the mask.
// - Invert bit zero passes the pin level; invert bit one reverses it.
// - A set force-enable bit replaces the sampled input with its force-value bit.
// - Force-value bits give the level, before the invert bit is applied, of each forced input.
// - Raw-value register shows sampled levels untouched by inversion, forcing or routing.
// - Threshold-select bit n picks input n+1 threshold: zero low, one high.
// - Each per-input register bit affects only the input at its position.
// - Image bit 0 carries negative-limit result; bit 16 the computed level of input 1.
// - Writing one to routing enable makes each image bit follow a selectable source.
// - In routing mode the enable, invert and force registers have no effect.
// - Entering routing loads selectors so inputs behave exactly as before.
// - Route selector n chooses the source for image bit n minus one.
// - Top code bit selects the inverted source; 80 is constant one.
// - Physical output k follows output image bit fifteen plus k.
// - Only output special-function bit 0 is used; it drives the brake.
// - Output invert clear drives high for image one; set drives low for one.
// - A manual-enable bit makes the output follow the manual-value bit, brake included.
// - Manual-value bits give the level applied to each manually driven output.
// - The first and fifth output configuration entries have no effect.
// - Images hold special bits in 0-15 and level bits in 16-31.
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

// ----------------------------------------------------------------------------
// Object addresses
// ----------------------------------------------------------------------------
`define ADR_SF_ENABLE      8'h01
`define ADR_IN_INVERT      8'h02
`define ADR_IN_FORCE_EN    8'h03
`define ADR_IN_FORCE_VAL   8'h04
`define ADR_IN_RAW         8'h05
`define ADR_IN_THRESH      8'h06
`define ADR_IN_ROUTE_EN    8'h08
`define ADR_IN_IMAGE       8'h10
`define ADR_OUT_IMAGE      8'h11
`define ADR_OUT_UNUSED     8'h21
`define ADR_OUT_INVERT     8'h22
`define ADR_OUT_MAN_EN     8'h23
`define ADR_OUT_MAN_VAL    8'h24
`define ADR_OUT_COMPAT     8'h25
`define ADR_ROUTE_BASE     8'h40
`define ADR_ROUTE_LAST     8'h60

// ----------------------------------------------------------------------------
// Field layout and codes
// ----------------------------------------------------------------------------
`define LVL_BASE           16
`define SF_INPUTS          3
`define SRC_INV_BIT        7
`define SRC_ZERO           7'h00
`define SRC_PIN_FIRST      7'h01
`define SRC_PIN_LAST       7'h10
`define SRC_HALL_U         7'h41
`define SRC_HALL_V         7'h42
`define SRC_HALL_W         7'h43
`define SRC_ENC_A          7'h44
`define SRC_ENC_B          7'h45
`define SRC_ENC_I          7'h46
`define CODE_INV           8'h80
`define WORD_RESET         32'h0000_0000
`define SEL_RESET          8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TICK_MS            1
`define CLK_KHZ            250000

`endif

/* File: rtl/dio_pkg.sv */
package dio_pkg;

    // ------------------------------------------------------------------------
    // Object access request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } acc_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } acc_rsp_t;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b01,
        MODE_ROUTING = 2'b10
    } in_mode_t;

endpackage : dio_pkg

/* File: rtl/digital_io_conditioning.sv */
`timescale 1ns/1ps
`include "dio_cfg.svh"

module digital_io_conditioning #(
    parameter int unsigned TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             acc_valid_i,
    input  wire dio_pkg::acc_req_t acc_req_i,
    output dio_pkg::acc_rsp_t     acc_rsp_o,
    input  wire logic [15:0]      din_i,
    input  wire logic [2:0]       hall_i,
    input  wire logic [2:0]       enc_i,
    output logic [15:0]           thresh_sel_o,
    output logic [15:0]           dout_o,
    output logic [15:0]           dout_oe_n_o,
    output logic                  brake_o,
    output logic                  brake_oe_n_o
);

    // ------------------------------------------------------------------------
    // Millisecond sampling tick
    // ------------------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic        tick_q;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CYCLES - 1) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q     <= 1'b0;
        end
    end

    // Pins are only looked at on the tick, so a pulse shorter than a tick is
    // missed unless it happens to straddle a sample point.
    logic [15:0] raw_q;
    logic [2:0]  hall_q;
    logic [2:0]  enc_q;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            raw_q  <= 16'h0000;
            hall_q <= 3'h0;
            enc_q  <= 3'h0;
        end else if (tick_q) begin
            raw_q  <= din_i;
            hall_q <= hall_i;
            enc_q  <= enc_i;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration objects
    // ------------------------------------------------------------------------
    logic [31:0] sf_en_q, in_inv_q, force_en_q, force_val_q, thresh_q;
    logic [31:0] out_img_q, out_inv_q, man_en_q, man_val_q;
    logic [31:0] in_img_q;
    logic [7:0]  route_en_q;
    logic [7:0]  route_sel_q [32];
    dio_pkg::in_mode_t mode_q;

    logic        wr, rd;
    logic [7:0]  adr;
    logic [31:0] wd;
    assign wr  = acc_valid_i & acc_req_i.write;
    assign rd  = acc_valid_i & ~acc_req_i.write;
    assign adr = acc_req_i.addr;
    assign wd  = acc_req_i.wdata;

    function automatic logic is_route(input logic [7:0] a);
        is_route = (a > `ADR_ROUTE_BASE) && (a <= `ADR_ROUTE_LAST);
    endfunction : is_route

    // Selector code that reproduces the normal path for one level bit.
    function automatic logic [7:0] normal_code(input int unsigned i, input logic fe, input logic fv,
                                               input logic inv);
        logic [7:0] c;
        c = 8'(i + 1);
        if (fe) begin
            normal_code = (fv ^ inv) ? `CODE_INV : {1'b0, `SRC_ZERO};
        end else begin
            normal_code = inv ? (c | `CODE_INV) : c;
        end
    endfunction : normal_code

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sf_en_q     <= `WORD_RESET;
            in_inv_q    <= `WORD_RESET;
            force_en_q  <= `WORD_RESET;
            force_val_q <= `WORD_RESET;
            thresh_q    <= `WORD_RESET;
            out_img_q   <= `WORD_RESET;
            out_inv_q   <= `WORD_RESET;
            man_en_q    <= `WORD_RESET;
            man_val_q   <= `WORD_RESET;
        end else if (wr) begin
            case (adr)
                `ADR_SF_ENABLE:    sf_en_q     <= wd;
                `ADR_IN_INVERT:    in_inv_q    <= wd;
                `ADR_IN_FORCE_EN:  force_en_q  <= wd;
                `ADR_IN_FORCE_VAL: force_val_q <= wd;
                `ADR_IN_THRESH:    thresh_q    <= wd;
                `ADR_OUT_IMAGE:    out_img_q   <= wd;
                `ADR_OUT_INVERT:   out_inv_q   <= wd;
                `ADR_OUT_MAN_EN:   man_en_q    <= wd;
                `ADR_OUT_MAN_VAL:  man_val_q   <= wd;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            route_en_q <= 8'h00;
            mode_q     <= dio_pkg::MODE_NORMAL;
        end else if (wr && adr == `ADR_IN_ROUTE_EN) begin
            route_en_q <= wd[7:0];
            mode_q     <= (wd[7:0] == 8'h01) ? dio_pkg::MODE_ROUTING : dio_pkg::MODE_NORMAL;
        end
    end

    // Entering routing mode overwrites every selector so the image does not
    // jump; software that toggles modes loses its own selector settings.
    logic enter_route;
    assign enter_route = wr && adr == `ADR_IN_ROUTE_EN && wd[7:0] == 8'h01 &&
                         mode_q != dio_pkg::MODE_ROUTING;

    generate
        for (genvar n = 0; n < 32; n++) begin : g_sel
            // Special and level selectors of one input copy the same path, so both use its index.
            localparam int unsigned SRC_IDX = n % `LVL_BASE;
            always_ff @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    route_sel_q[n] <= `SEL_RESET;
                end else if (enter_route) begin
                    if (n >= `LVL_BASE || (n < `SF_INPUTS && sf_en_q[SRC_IDX])) begin
                        route_sel_q[n] <= normal_code(SRC_IDX, force_en_q[SRC_IDX], force_val_q[SRC_IDX],
                                                      in_inv_q[SRC_IDX]);
                    end else begin
                        route_sel_q[n] <= `SEL_RESET;
                    end
                end else if (wr && adr == `ADR_ROUTE_BASE + 8'(n + 1)) begin
                    route_sel_q[n] <= wd[7:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Input image
    // ------------------------------------------------------------------------
    function automatic logic route_src(input logic [7:0] code, input logic [15:0] pins,
                                       input logic [2:0] hall, input logic [2:0] enc);
        logic [6:0] s;
        logic       v;
        s = code[6:0];
        v = 1'b0;
        if (s >= `SRC_PIN_FIRST && s <= `SRC_PIN_LAST) begin
            v = pins[4'(s - `SRC_PIN_FIRST)];
        end else begin
            case (s)
                `SRC_HALL_U: v = hall[0];
                `SRC_HALL_V: v = hall[1];
                `SRC_HALL_W: v = hall[2];
                `SRC_ENC_A:  v = enc[0];
                `SRC_ENC_B:  v = enc[1];
                `SRC_ENC_I:  v = enc[2];
                default:     v = 1'b0;
            endcase
        end
        route_src = v ^ code[`SRC_INV_BIT];
    endfunction : route_src

    logic [15:0] lvl;
    logic [31:0] img_d;

    // Forcing comes before inversion, so a forced input still obeys its invert bit.
    generate
        for (genvar i = 0; i < 16; i++) begin : g_lvl
            assign lvl[i] = (force_en_q[i] ? force_val_q[i] : raw_q[i]) ^ in_inv_q[i];
        end
    endgenerate

    generate
        for (genvar n = 0; n < 32; n++) begin : g_img
            logic normal_bit;
            if (n >= `LVL_BASE) begin : g_level
                assign normal_bit = lvl[n - `LVL_BASE];
            end else if (n < `SF_INPUTS) begin : g_special
                assign normal_bit = sf_en_q[n] & lvl[n];
            end else begin : g_spare
                assign normal_bit = 1'b0;
            end
            assign img_d[n] = (mode_q == dio_pkg::MODE_ROUTING) ?
                              route_src(route_sel_q[n], raw_q, hall_q, enc_q) : normal_bit;
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_img_q <= `WORD_RESET;
        end else begin
            in_img_q <= img_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    function automatic logic out_level(input logic img, input logic inv, input logic me, input logic mv);
        out_level = me ? mv : (img ^ inv);
    endfunction : out_level

    logic [15:0] dout_d;
    logic        brake_d;

    generate
        for (genvar k = 0; k < 16; k++) begin : g_out
            assign dout_d[k] = out_level(out_img_q[k + `LVL_BASE], out_inv_q[k + `LVL_BASE],
                                         man_en_q[k + `LVL_BASE], man_val_q[k + `LVL_BASE]);
        end
    endgenerate

    assign brake_d = out_level(out_img_q[0], out_inv_q[0], man_en_q[0], man_val_q[0]);

    // Open-drain pads: enable is low only while pulling the pin low.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_o       <= 16'h0000;
            dout_oe_n_o  <= 16'hffff;
            brake_o      <= 1'b0;
            brake_oe_n_o <= 1'b1;
            thresh_sel_o <= 16'h0000;
        end else begin
            dout_o       <= dout_d;
            dout_oe_n_o  <= dout_d;
            brake_o      <= brake_d;
            brake_oe_n_o <= brake_d;
            thresh_sel_o <= thresh_q[15:0];
        end
    end

    // ------------------------------------------------------------------------
    // Object read path
    // ------------------------------------------------------------------------
    logic [31:0] rdata_d;
    logic        err_d;

    always_comb begin
        err_d   = 1'b0;
        rdata_d = `WORD_RESET;
        case (adr)
            `ADR_SF_ENABLE:    rdata_d = sf_en_q;
            `ADR_IN_INVERT:    rdata_d = in_inv_q;
            `ADR_IN_FORCE_EN:  rdata_d = force_en_q;
            `ADR_IN_FORCE_VAL: rdata_d = force_val_q;
            `ADR_IN_RAW:       rdata_d = {16'h0000, raw_q};
            `ADR_IN_THRESH:    rdata_d = thresh_q;
            `ADR_IN_ROUTE_EN:  rdata_d = {24'h00_0000, route_en_q};
            `ADR_IN_IMAGE:     rdata_d = in_img_q;
            `ADR_OUT_IMAGE:    rdata_d = out_img_q;
            `ADR_OUT_INVERT:   rdata_d = out_inv_q;
            `ADR_OUT_MAN_EN:   rdata_d = man_en_q;
            `ADR_OUT_MAN_VAL:  rdata_d = man_val_q;
            `ADR_OUT_UNUSED,
            `ADR_OUT_COMPAT:   rdata_d = `WORD_RESET;
            default: begin
                if (is_route(adr)) begin
                    rdata_d = {24'h00_0000, route_sel_q[5'(adr - `ADR_ROUTE_BASE - 8'h01)]};
                end else begin
                    err_d = 1'b1;
                end
            end
        endcase
        if (!rd) begin
            rdata_d = `WORD_RESET;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_rsp_o <= '0;
        end else begin
            acc_rsp_o.ack   <= acc_valid_i;
            acc_rsp_o.err   <= acc_valid_i & err_d;
            acc_rsp_o.rdata <= rdata_d;
        end
    end

endmodule : digital_io_conditioning

/* File: test/dio_monitor.sv */
`timescale 1ns/1ps
module dio_monitor (
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic              acc_valid_i,
    input wire dio_pkg::acc_req_t acc_req_i,
    input wire dio_pkg::acc_rsp_t acc_rsp_o,
    input wire logic [15:0]       din_i,
    input wire logic [2:0]        hall_i,
    input wire logic [2:0]        enc_i,
    input wire logic [15:0]       thresh_sel_o,
    input wire logic [15:0]       dout_o,
    input wire logic [15:0]       dout_oe_n_o,
    input wire logic              brake_o,
    input wire logic              brake_oe_n_o
);
    // --------
    // Checks
    // --------
    logic        settled_q;
    logic        hit;
    logic        rsvd;
    logic [15:0] wlo;
    assign wlo  = acc_req_i.wdata[15:0];
    assign rsvd = acc_req_i.addr inside {8'h21, 8'h25};
    assign hit  = acc_req_i.addr inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h10, 8'h11,
                  8'h21, 8'h22, 8'h23, 8'h24, 8'h25} || (acc_req_i.addr >= 8'h41 && acc_req_i.addr <= 8'h60);
    // The pins only settle one edge after reset ends, so the pin check waits for it.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            settled_q <= 1'b0;
        end else begin
            settled_q <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (acc_valid_i |=> acc_rsp_o.ack)
        else $error("ack missing");
    a_no_stray_ack: assert property (!acc_valid_i |=> !acc_rsp_o.ack)
        else $error("ack without request");
    a_err_unmapped: assert property (acc_valid_i && !hit |=> acc_rsp_o.err)
        else $error("no error for unmapped address");
    a_err_mapped: assert property (acc_valid_i && hit |=> !acc_rsp_o.err)
        else $error("error for mapped address");
    a_rdata_idle: assert property (!acc_rsp_o.ack |-> acc_rsp_o.rdata == 32'h0000_0000)
        else $error("read data outside answer");
    a_reserved_read: assert property (acc_valid_i && !acc_req_i.write && rsvd
        |=> acc_rsp_o.rdata == 32'h0000_0000) else $error("reserved entry reads nonzero");
    a_oe_follows: assert property (settled_q |-> dout_oe_n_o == dout_o)
        else $error("pin enable differs from level");
    a_thresh_follow: assert property (acc_valid_i && acc_req_i.write && acc_req_i.addr == 8'h06
        |=> ##1 thresh_sel_o == $past(wlo, 2)) else $error("threshold select not applied");
endmodule : dio_monitor

/* File: test/pin_field.sv */
`timescale 1ns/1ps
module pin_field (
    input  wire logic [15:0] level_i,
    input  wire logic [15:0] oe_n_i,
    input  wire logic        brake_oe_n_i,
    output logic [15:0]      din_o,
    output logic [15:0]      pin_o,
    output logic             brake_pin_o
);
    // --------
    // Switches and loads
    // --------
    // Limit and home switches sit on pins 1 to 3 and reach the inputs unchanged.
    assign din_o       = level_i;
    // Pull-ups raise every released line, so a pin is low only while pulled.
    assign pin_o       = oe_n_i;
    assign brake_pin_o = brake_oe_n_i;
endmodule : pin_field

/* File: test/digital_io_conditioning_tb.sv */
`timescale 1ns/1ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (x)); end end
module digital_io_conditioning_tb;
    localparam int unsigned TICKS = 8;
    logic              clk;
    logic              rst;
    logic              vld;
    dio_pkg::acc_req_t req;
    dio_pkg::acc_rsp_t rsp;
    logic [15:0]       lvl;
    logic [15:0]       din;
    logic [2:0]        hall;
    logic [2:0]        enc;
    logic [15:0]       thr;
    logic [15:0]       dout;
    logic [15:0]       oe_n;
    logic              brk;
    logic              brk_oe_n;
    logic [15:0]       pin;
    logic              brk_pin;
    logic [31:0]       q;
    logic              e;
    int                error_cnt;
    int                check_count;
    // --------
    // Harness
    // --------
    digital_io_conditioning #(.TICK_CYCLES(TICKS)) dut (.core_clk_i(clk), .rst_i(rst), .acc_valid_i(vld),
        .acc_req_i(req), .acc_rsp_o(rsp), .din_i(din), .hall_i(hall), .enc_i(enc), .thresh_sel_o(thr),
        .dout_o(dout), .dout_oe_n_o(oe_n), .brake_o(brk), .brake_oe_n_o(brk_oe_n));
    pin_field field (.level_i(lvl), .oe_n_i(oe_n), .brake_oe_n_i(brk_oe_n), .din_o(din), .pin_o(pin),
        .brake_pin_o(brk_pin));
    task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) #1;
        vld = 1'b1;
        req = '{write: w, addr: a, wdata: d};
        @(posedge clk) #1;
        vld = 1'b0;
        while (rsp.ack !== 1'b1 && n < 4) begin
            @(posedge clk) #1;
            n++;
        end
        `CHK(rsp.ack, 1'b1)
        q = rsp.rdata;
        e = rsp.err;
    endtask : io
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        io(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        io(1'b0, a, 32'h0000_0000);
        `CHK(q, x)
    endtask : rd_chk
    task automatic t_reset;
        logic [7:0] regs [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h10, 8'h11, 8'h22, 8'h23,
                                  8'h24, 8'h41, 8'h60};
        foreach (regs[i]) begin
            rd_chk(regs[i], 32'h0000_0000);
        end
        io(1'b0, 8'h07, 32'h0000_0000);
        `CHK(e, 1'b1)
        io(1'b1, 8'h30, 32'hffff_ffff);
        `CHK(e, 1'b1)
        wr(8'h05, 32'hffff_ffff);
        rd_chk(8'h05, 32'h0000_0000);
        wr(8'h10, 32'hffff_ffff);
        rd_chk(8'h10, 32'h0000_0000);
    endtask : t_reset
    task automatic t_inputs;
        logic [15:0] lv;
        lvl = 16'ha5c3;
        wr(8'h01, 32'h0000_0005);
        wr(8'h02, 32'h0000_00f0);
        wr(8'h03, 32'h0000_0303);
        wr(8'h04, 32'h0000_0101);
        wr(8'h06, 32'h0000_0005);
        repeat (3 * TICKS) @(posedge clk);
        lv = ((lvl & ~16'h0303) | 16'h0101) ^ 16'h00f0;
        rd_chk(8'h05, {16'h0000, lvl});
        rd_chk(8'h10, {lv, 13'h0, lv[2:0] & 3'b101});
        `CHK(thr, 16'h0005)
    endtask : t_inputs
    task automatic t_routing;
        logic [15:0] lv;
        logic [5:0]  v;
        logic [7:0]  c;
        lv = ((lvl & ~16'h0303) | 16'h0101) ^ 16'h00f0;
        v = {enc, hall};
        wr(8'h08, 32'h0000_0001);
        rd_chk(8'h10, {lv, 13'h0, lv[2:0] & 3'b101});
        rd_chk(8'h55, 32'h0000_0085);
        wr(8'h41, 32'h0000_0080);
        wr(8'h42, 32'h0000_0041);
        wr(8'h43, 32'h0000_00c5);
        wr(8'h51, 32'h0000_0002);
        wr(8'h52, 32'h0000_0083);
        wr(8'h02, 32'h0000_0000);
        repeat (3 * TICKS) @(posedge clk);
        io(1'b0, 8'h10, 32'h0000_0000);
        `CHK(q & 32'h0013_0007, {11'h0, lv[4], 2'b00, ~lvl[2], lvl[1], 13'h0, 3'b011})
        for (int k = 1; k <= 22; k++) begin
            c = (k <= 16) ? 8'(k) : 8'(8'h40 + k - 16);
            wr(8'h44, {24'h000000, c});
            wr(8'h45, {24'h000000, c | 8'h80});
            repeat (TICKS + 3) @(posedge clk);
            io(1'b0, 8'h10, 32'h0000_0000);
            `CHK(q[4:3], (k <= 16) ? {~lvl[k-1], lvl[k-1]} : {~v[k-17], v[k-17]})
        end
        wr(8'h08, 32'h0000_0000);
        repeat (3 * TICKS) @(posedge clk);
        lv = (lvl & ~16'h0303) | 16'h0101;
        rd_chk(8'h10, {lv, 13'h0, lv[2:0] & 3'b101});
    endtask : t_routing
    task automatic t_outputs;
        wr(8'h11, 32'h8001_0001);
        wr(8'h22, 32'h0003_0000);
        @(posedge clk) #1;
        `CHK(dout, 16'h8002)
        `CHK(pin, 16'h8002)
        `CHK(brk, 1'b1)
        `CHK(brk_pin, 1'b1)
        wr(8'h23, 32'h8001_0001);
        wr(8'h24, 32'h0001_0000);
        wr(8'h21, 32'hffff_ffff);
        wr(8'h25, 32'hffff_ffff);
        @(posedge clk) #1;
        `CHK(dout, 16'h0003)
        `CHK(brk, 1'b0)
        `CHK(brk_pin, 1'b0)
        rd_chk(8'h25, 32'h0000_0000);
    endtask : t_outputs
    task automatic conclude;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // The watchdog span is far above the few hundred cycles the tests need.
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial begin
        error_cnt = 0;
        check_count = 0;
        rst = 1'b1;
        vld = 1'b0;
        req = '0;
        lvl = 16'h0000;
        hall = 3'b101;
        enc = 3'b010;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_inputs();
        t_routing();
        t_outputs();
        conclude();
    end
endmodule : digital_io_conditioning_tb
bind digital_io_conditioning dio_monitor u_mon (.core_clk_i(core_clk_i), .rst_i(rst_i), .acc_valid_i(acc_valid_i),
    .acc_req_i(acc_req_i), .acc_rsp_o(acc_rsp_o), .din_i(din_i), .hall_i(hall_i), .enc_i(enc_i),
    .thresh_sel_o(thresh_sel_o), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .brake_o(brake_o),
    .brake_oe_n_o(brake_oe_n_o));
